// File: common/adc_limit_pkg.sv
// Overview of operation
// - low check active only when bound nonzero
// - high check active only below maximum code
// - summary flags rise when a conversion sets a limit bit
// - low summary clears once all low bits cleared
// - high summary clears once all high bits cleared
// - low request needs low flag and enable
// - high request needs high flag and enable
// - sixteen ready bits, one per slot
// - ready bit set when its conversion finishes
// - reading a result clears its ready bit
// - result below low bound sets low bit
// - result above high bound sets high bit
// - limit bits are sticky across conversions
// - writing one clears a bit, zero keeps
// - undefined summary bits carry no meaning
// - compare raw value, no offset correction
// - bounds reset to their disabled values
package adc_limit_pkg;

   localparam int SLOT_MAX   = 16;
   localparam int SLOT_IDX_W = 4;
   localparam int ADDR_W     = 8;
   localparam int DATA_W     = 32;

   // control region, region bits are addr[7:6]
   localparam logic [7:0] OFF_SUMMARY     = 8'h00;
   localparam logic [7:0] OFF_READY       = 8'h04;
   localparam logic [7:0] OFF_LOW_STAT    = 8'h08;
   localparam logic [7:0] OFF_HIGH_STAT   = 8'h0c;
   localparam logic [7:0] OFF_CONTROL     = 8'h10;
   localparam logic [7:0] OFF_IRQ_STAT    = 8'h14;
   localparam logic [7:0] OFF_IRQ_MASK    = 8'h18;
   localparam logic [7:0] OFF_RESULT_BASE = 8'h40;
   localparam logic [7:0] OFF_LOW_BASE    = 8'h80;
   localparam logic [7:0] OFF_HIGH_BASE   = 8'hc0;

   // summary register fields
   localparam int SUM_LOW_BIT  = 9;
   localparam int SUM_HIGH_BIT = 8;
   // control_one fields
   localparam int CTRL_LOW_EN_BIT  = 1;
   localparam int CTRL_HIGH_EN_BIT = 0;
   // interrupt status and mask fields
   localparam int IRQ_CONV_BIT = 0;
   localparam int IRQ_LOW_BIT  = 1;
   localparam int IRQ_HIGH_BIT = 2;
   localparam int IRQ_W        = 3;

   localparam logic [15:0] LOW_DISABLED     = 16'h0000;
   localparam logic [15:0] HIGH_DISABLED    = 16'h7ff8;
   localparam logic [15:0] LIMIT_FIELD_MASK = 16'h7ff8;
   localparam logic        CTRL_EN_RESET    = 1'b0;

   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

// File: rtl/adc_limit_ready_status.sv
// Chosen here: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
module adc_limit_ready_status #(
   parameter int SLOTS = adc_limit_pkg::SLOT_MAX
) (
   input  wire logic                                  clk_sys,
   input  wire logic                                  sys_rst,
   input  wire logic [adc_limit_pkg::ADDR_W-1:0]      s_axi_awaddr,
   input  wire logic                                  s_axi_awvalid,
   output logic                                       s_axi_awready,
   input  wire logic [adc_limit_pkg::DATA_W-1:0]      s_axi_wdata,
   input  wire logic [3:0]                            s_axi_wstrb,
   input  wire logic                                  s_axi_wvalid,
   output logic                                       s_axi_wready,
   output logic [1:0]                                 s_axi_bresp,
   output logic                                       s_axi_bvalid,
   input  wire logic                                  s_axi_bready,
   input  wire logic [adc_limit_pkg::ADDR_W-1:0]      s_axi_araddr,
   input  wire logic                                  s_axi_arvalid,
   output logic                                       s_axi_arready,
   output logic [adc_limit_pkg::DATA_W-1:0]           s_axi_rdata,
   output logic [1:0]                                 s_axi_rresp,
   output logic                                       s_axi_rvalid,
   input  wire logic                                  s_axi_rready,
   input  wire logic                                  conv_done,
   input  wire logic [adc_limit_pkg::SLOT_IDX_W-1:0]  conv_slot,
   input  wire logic [15:0]                           conversion_result,
   output logic                                       low_limit_req,
   output logic                                       high_limit_req,
   output logic                                       irq
);
   import adc_limit_pkg::*;

   if (SLOTS < 1 || SLOTS > SLOT_MAX) begin : g_bad_slots
      $error("SLOTS must lie between 1 and 16");
   end

   typedef struct packed {
      logic [SLOTS-1:0][15:0] result;
      logic [SLOTS-1:0][15:0] low_bound_value;
      logic [SLOTS-1:0][15:0] high_bound_value;
      logic [SLOTS-1:0]       ready;
      logic [SLOTS-1:0]       low_limit_hit_bits;
      logic [SLOTS-1:0]       high_limit_hit_bits;
      logic                   low_limit_irq_enable;
      logic                   high_limit_irq_enable;
      logic [IRQ_W-1:0]       irq_stat;
      logic [IRQ_W-1:0]       irq_mask;
      logic                   aw_held;
      logic [ADDR_W-1:0]      aw_addr;
      logic                   w_held;
      logic [DATA_W-1:0]      w_data;
      logic [3:0]             w_strb;
      logic                   bvalid;
      logic [1:0]             bresp;
      logic                   rvalid;
      logic [DATA_W-1:0]      rdata;
      logic [1:0]             rresp;
   } state_s;

   state_s              st_q;
   state_s              st_d;
   logic                aw_fire;
   logic                w_fire;
   logic                ar_fire;
   logic                do_write;
   logic [7:0]          wr_word;
   logic [1:0]          wr_region;
   logic [3:0]          wr_index;
   logic                wr_idx_ok;
   logic                wr_hit;
   logic [15:0]         wr_lanes;
   logic [15:0]         wr_clr16;
   logic [SLOTS-1:0]    low_clr;
   logic [SLOTS-1:0]    high_clr;
   logic [IRQ_W-1:0]    irq_clr;
   logic [7:0]          rd_word_addr;
   logic [1:0]          rd_region;
   logic [3:0]          rd_index;
   logic                rd_idx_ok;
   logic                rd_ok;
   logic [DATA_W-1:0]   rd_word;
   logic                rd_result;
   logic                conv_ok;
   logic [15:0]         conv_raw_field;
   logic                low_chk_on;
   logic                high_chk_on;
   logic                low_ev;
   logic                high_ev;
   logic                low_limit_irq_flag;
   logic                high_limit_irq_flag;
   logic [SLOTS-1:0]    keep_low;
   logic [SLOTS-1:0]    keep_high;

   // bus handshakes: one write and one read in flight
   assign s_axi_awready = !st_q.aw_held && !st_q.bvalid;
   assign s_axi_wready  = !st_q.w_held && !st_q.bvalid;
   assign s_axi_arready = !st_q.rvalid;
   assign aw_fire  = s_axi_awvalid && s_axi_awready;
   assign w_fire   = s_axi_wvalid && s_axi_wready;
   assign ar_fire  = s_axi_arvalid && s_axi_arready;
   assign do_write = st_q.aw_held && st_q.w_held && !st_q.bvalid;

   assign s_axi_bvalid = st_q.bvalid;
   assign s_axi_bresp  = st_q.bresp;
   assign s_axi_rvalid = st_q.rvalid;
   assign s_axi_rdata  = st_q.rdata;
   assign s_axi_rresp  = st_q.rresp;

   // write decode
   assign wr_word   = {st_q.aw_addr[7:2], 2'b00};
   assign wr_region = st_q.aw_addr[7:6];
   assign wr_index  = st_q.aw_addr[5:2];
   assign wr_idx_ok = int'(wr_index) < SLOTS;
   assign wr_lanes  = {{8{st_q.w_strb[1]}}, {8{st_q.w_strb[0]}}};
   assign wr_clr16  = st_q.w_data[15:0] & wr_lanes;

   always_comb begin
      wr_hit = 1'b0;
      if (wr_region == OFF_SUMMARY[7:6]) begin
         case (wr_word)
            OFF_SUMMARY, OFF_READY, OFF_LOW_STAT, OFF_HIGH_STAT,
            OFF_CONTROL, OFF_IRQ_STAT, OFF_IRQ_MASK: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
         endcase
      end else begin
         wr_hit = wr_idx_ok;
      end
   end

   // write-one-to-clear masks, zeros leave bits alone
   assign low_clr  = (do_write && wr_word == OFF_LOW_STAT) ?
                     wr_clr16[SLOTS-1:0] : '0;
   assign high_clr = (do_write && wr_word == OFF_HIGH_STAT) ?
                     wr_clr16[SLOTS-1:0] : '0;
   assign irq_clr  = (do_write && wr_word == OFF_IRQ_STAT) ?
                     wr_clr16[IRQ_W-1:0] : '0;

   // read decode
   assign rd_word_addr = {s_axi_araddr[7:2], 2'b00};
   assign rd_region    = s_axi_araddr[7:6];
   assign rd_index     = s_axi_araddr[5:2];
   assign rd_idx_ok    = int'(rd_index) < SLOTS;
   assign rd_result    = ar_fire && rd_idx_ok &&
                         rd_region == OFF_RESULT_BASE[7:6];

   always_comb begin
      rd_word = '0;
      rd_ok   = 1'b1;
      if (rd_region == OFF_SUMMARY[7:6]) begin
         case (rd_word_addr)
            OFF_SUMMARY: begin
               // undefined positions simply read zero
               rd_word[SUM_LOW_BIT]  = low_limit_irq_flag;
               rd_word[SUM_HIGH_BIT] = high_limit_irq_flag;
            end
            OFF_READY: rd_word[SLOTS-1:0] = st_q.ready;
            OFF_LOW_STAT: rd_word[SLOTS-1:0] = st_q.low_limit_hit_bits;
            OFF_HIGH_STAT: rd_word[SLOTS-1:0] = st_q.high_limit_hit_bits;
            OFF_CONTROL: begin
               rd_word[CTRL_LOW_EN_BIT]  = st_q.low_limit_irq_enable;
               rd_word[CTRL_HIGH_EN_BIT] = st_q.high_limit_irq_enable;
            end
            OFF_IRQ_STAT: rd_word[IRQ_W-1:0] = st_q.irq_stat;
            OFF_IRQ_MASK: rd_word[IRQ_W-1:0] = st_q.irq_mask;
            default: rd_ok = 1'b0;
         endcase
      end else if (!rd_idx_ok) begin
         rd_ok = 1'b0;
      end else if (rd_region == OFF_RESULT_BASE[7:6]) begin
         rd_word[15:0] = st_q.result[rd_index];
      end else if (rd_region == OFF_LOW_BASE[7:6]) begin
         rd_word[15:0] = st_q.low_bound_value[rd_index];
      end else begin
         rd_word[15:0] = st_q.high_bound_value[rd_index];
      end
   end

   // limit checks on the raw sample, no offset applied
   assign conv_ok        = conv_done && int'(conv_slot) < SLOTS;
   assign conv_raw_field = conversion_result & LIMIT_FIELD_MASK;
   assign low_chk_on  =
      st_q.low_bound_value[conv_slot] != LOW_DISABLED;
   assign high_chk_on =
      st_q.high_bound_value[conv_slot] != HIGH_DISABLED;
   assign low_ev  = conv_ok && low_chk_on &&
      conv_raw_field < st_q.low_bound_value[conv_slot];
   assign high_ev = conv_ok && high_chk_on &&
      conv_raw_field > st_q.high_bound_value[conv_slot];

   // summary flags follow the per-slot bits
   assign low_limit_irq_flag  = |st_q.low_limit_hit_bits;
   assign high_limit_irq_flag = |st_q.high_limit_hit_bits;
   assign low_limit_req  =
      low_limit_irq_flag && st_q.low_limit_irq_enable;
   assign high_limit_req =
      high_limit_irq_flag && st_q.high_limit_irq_enable;
   assign irq = |(st_q.irq_stat & st_q.irq_mask);

   always_comb begin
      st_d = st_q;
      if (aw_fire) begin
         st_d.aw_held = 1'b1;
         st_d.aw_addr = s_axi_awaddr;
      end
      if (w_fire) begin
         st_d.w_held = 1'b1;
         st_d.w_data = s_axi_wdata;
         st_d.w_strb = s_axi_wstrb;
      end
      if (st_q.bvalid && s_axi_bready) begin
         st_d.bvalid = 1'b0;
      end
      if (do_write) begin
         st_d.aw_held = 1'b0;
         st_d.w_held  = 1'b0;
         st_d.bvalid  = 1'b1;
         st_d.bresp   = wr_hit ? RESP_OKAY : RESP_SLVERR;
         if (wr_word == OFF_CONTROL) begin
            if (st_q.w_strb[0]) begin
               st_d.low_limit_irq_enable  = st_q.w_data[CTRL_LOW_EN_BIT];
               st_d.high_limit_irq_enable = st_q.w_data[CTRL_HIGH_EN_BIT];
            end
         end
         if (wr_word == OFF_IRQ_MASK && st_q.w_strb[0]) begin
            st_d.irq_mask = st_q.w_data[IRQ_W-1:0];
         end
         if (wr_idx_ok && wr_region == OFF_LOW_BASE[7:6]) begin
            st_d.low_bound_value[wr_index] = LIMIT_FIELD_MASK &
               ((st_q.w_data[15:0] & wr_lanes) |
                (st_q.low_bound_value[wr_index] & ~wr_lanes));
         end
         if (wr_idx_ok && wr_region == OFF_HIGH_BASE[7:6]) begin
            st_d.high_bound_value[wr_index] = LIMIT_FIELD_MASK &
               ((st_q.w_data[15:0] & wr_lanes) |
                (st_q.high_bound_value[wr_index] & ~wr_lanes));
         end
      end
      st_d.low_limit_hit_bits  = st_q.low_limit_hit_bits & ~low_clr;
      st_d.high_limit_hit_bits = st_q.high_limit_hit_bits & ~high_clr;
      st_d.irq_stat            = st_q.irq_stat & ~irq_clr;

      if (st_q.rvalid && s_axi_rready) begin
         st_d.rvalid = 1'b0;
      end
      if (ar_fire) begin
         st_d.rvalid = 1'b1;
         st_d.rdata  = rd_word;
         st_d.rresp  = rd_ok ? RESP_OKAY : RESP_SLVERR;
      end
      if (rd_result) begin
         st_d.ready[rd_index] = 1'b0;
      end

      // conversion sets come last so they win over clears
      if (conv_ok) begin
         st_d.result[conv_slot] = conversion_result;
         st_d.ready[conv_slot]  = 1'b1;
         st_d.irq_stat[IRQ_CONV_BIT] = 1'b1;
         if (low_ev) begin
            st_d.low_limit_hit_bits[conv_slot] = 1'b1;
            st_d.irq_stat[IRQ_LOW_BIT] = 1'b1;
         end
         if (high_ev) begin
            st_d.high_limit_hit_bits[conv_slot] = 1'b1;
            st_d.irq_stat[IRQ_HIGH_BIT] = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         st_q <= '0;
         st_q.low_bound_value  <= {SLOTS{LOW_DISABLED}};
         st_q.high_bound_value <= {SLOTS{HIGH_DISABLED}};
         st_q.low_limit_irq_enable  <= CTRL_EN_RESET;
         st_q.high_limit_irq_enable <= CTRL_EN_RESET;
      end else begin
         st_q <= st_d;
      end
   end

   // checks
   assign keep_low  = st_q.low_limit_hit_bits & ~low_clr;
   assign keep_high = st_q.high_limit_hit_bits & ~high_clr;

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (sys_rst);

   sequence s_low_clear_all;
      do_write && wr_word == OFF_LOW_STAT &&
      ((st_q.low_limit_hit_bits & ~low_clr) == '0) && !conv_done;
   endsequence

   sequence s_high_clear_all;
      do_write && wr_word == OFF_HIGH_STAT &&
      ((st_q.high_limit_hit_bits & ~high_clr) == '0) && !conv_done;
   endsequence

   a_ready_on_conv: assert property (
      conv_ok |=> st_q.ready[$past(conv_slot)])
      else $error("ready bit not set after conversion");

   a_ready_read_clr: assert property (
      rd_result && !(conv_done && conv_slot == rd_index)
      |=> !st_q.ready[$past(rd_index)] && s_axi_rvalid)
      else $error("ready bit not cleared by result read");

   a_low_hit_set: assert property (
      conv_ok && low_chk_on &&
      conv_raw_field < st_q.low_bound_value[conv_slot]
      |=> st_q.low_limit_hit_bits[$past(conv_slot)] && low_limit_irq_flag)
      else $error("low limit hit not latched");

   a_low_disabled: assert property (
      conv_ok && !low_chk_on && !st_q.low_limit_hit_bits[conv_slot]
      |=> !st_q.low_limit_hit_bits[$past(conv_slot)])
      else $error("low check active while disabled");

   a_high_hit_set: assert property (
      conv_ok && high_chk_on &&
      conv_raw_field > st_q.high_bound_value[conv_slot]
      |=> st_q.high_limit_hit_bits[$past(conv_slot)] && high_limit_irq_flag)
      else $error("high limit hit not latched");

   a_high_disabled: assert property (
      conv_ok && !high_chk_on && !st_q.high_limit_hit_bits[conv_slot]
      |=> !st_q.high_limit_hit_bits[$past(conv_slot)])
      else $error("high check active while disabled");

   a_hits_sticky: assert property (
      1'b1 |=> ((st_q.low_limit_hit_bits & $past(keep_low))
                 == $past(keep_low)) &&
               ((st_q.high_limit_hit_bits & $past(keep_high))
                 == $past(keep_high)))
      else $error("limit bit lost without a one written");

   a_low_req_gate: assert property (
      low_ev && st_q.low_limit_irq_enable && !do_write
      |=> low_limit_req)
      else $error("low request missing with enable set");

   a_high_req_gate: assert property (
      high_ev && !st_q.high_limit_irq_enable && !do_write
      |=> high_limit_irq_flag && !high_limit_req)
      else $error("high request raised while disabled");

   a_low_sum_clear: assert property (
      s_low_clear_all |=> !low_limit_irq_flag && !low_limit_req)
      else $error("low summary stuck after full clear");

   a_high_sum_clear: assert property (
      s_high_clear_all |=> !high_limit_irq_flag && !high_limit_req)
      else $error("high summary stuck after full clear");

   a_bound_reset: assert property (
      $fell(sys_rst) |-> st_q.low_bound_value == '0 &&
      st_q.high_bound_value == {SLOTS{HIGH_DISABLED}})
      else $error("limit bounds not disabled after reset");

endmodule

// File: verification/adc_limit_ready_status_test.sv
`timescale 1ns/1ps
module adc_limit_ready_status_test;
   import adc_limit_pkg::*;

   typedef struct {
      int          slot;
      logic [15:0] raw;
      logic [15:0] lo;
      logic [15:0] hi;
      logic        exp_lo;
      logic        exp_hi;
   } row_s;

   logic        clk_sys;
   logic        sys_rst;
   logic [7:0]  s_axi_awaddr;
   logic        s_axi_awvalid;
   logic        s_axi_awready;
   logic [31:0] s_axi_wdata;
   logic [3:0]  s_axi_wstrb;
   logic        s_axi_wvalid;
   logic        s_axi_wready;
   logic [1:0]  s_axi_bresp;
   logic        s_axi_bvalid;
   logic        s_axi_bready;
   logic [7:0]  s_axi_araddr;
   logic        s_axi_arvalid;
   logic        s_axi_arready;
   logic [31:0] s_axi_rdata;
   logic [1:0]  s_axi_rresp;
   logic        s_axi_rvalid;
   logic        s_axi_rready;
   logic        conv_done;
   logic [3:0]  conv_slot;
   logic [15:0] conversion_result;
   logic        low_limit_req;
   logic        high_limit_req;
   logic        irq;
   int          num_errors;
   int          comparisons;
   logic [1:0]  resp;
   logic [31:0] data;

   // slot, raw, low bound, high bound, low hit, high hit
   row_s rows [6] = '{
      '{2,  16'h0010, 16'h0100, 16'h7ff8, 1'b1, 1'b0},
      '{5,  16'h0100, 16'h0100, 16'h7ff8, 1'b0, 1'b0},
      '{0,  16'h0000, 16'h0000, 16'h7ff8, 1'b0, 1'b0},
      '{15, 16'h0108, 16'h0000, 16'h0100, 1'b0, 1'b1},
      '{7,  16'h7fff, 16'h0000, 16'h7ff8, 1'b0, 1'b0},
      '{9,  16'h0100, 16'h0108, 16'h00f8, 1'b1, 1'b1}};

   adc_limit_ready_status #(.SLOTS(16)) i_adc_limit_ready_status (.*);

   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   task automatic end_of_test;
      $display("comparisons %0d, mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic check_word(input logic [31:0] got, exp, mask);
      comparisons++;
      if ((got & mask) !== (exp & mask)) begin
         num_errors++;
         $display("mismatch at %0t: word %h, want %h", $time, got, exp);
      end
   endtask

   task automatic check_bit(input logic got, exp);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t: flag %b, want %b", $time, got, exp);
      end
   endtask

   task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                            output logic [1:0] r);
      logic b_done;
      @(posedge clk_sys);
      s_axi_awaddr  <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata   <= d;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      b_done = 1'b0;
      while (!b_done) begin
         @(posedge clk_sys);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) begin
            r = s_axi_bresp;
            s_axi_bready <= 1'b0;
            b_done = 1'b1;
         end
      end
   endtask

   task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
                           output logic [1:0] r);
      logic r_done;
      @(posedge clk_sys);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      r_done = 1'b0;
      while (!r_done) begin
         @(posedge clk_sys);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) begin
            d = s_axi_rdata;
            r = s_axi_rresp;
            s_axi_rready <= 1'b0;
            r_done = 1'b1;
         end
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [1:0] r;
      axi_write(a, d, r);
      check_word({30'h0000_0000, r}, {30'h0000_0000, RESP_OKAY}, 32'h3);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, mask);
      logic [31:0] d;
      logic [1:0]  r;
      axi_read(a, d, r);
      check_word({30'h0000_0000, r}, {30'h0000_0000, RESP_OKAY}, 32'h3);
      check_word(d, exp, mask);
   endtask

   task automatic conv(input int s, input logic [15:0] raw);
      @(posedge clk_sys);
      conv_done         <= 1'b1;
      conv_slot         <= 4'(s);
      conversion_result <= raw;
      @(posedge clk_sys);
      conv_done         <= 1'b0;
   endtask

   function automatic logic [7:0] at(input logic [7:0] base, input int s);
      return base + 8'(4 * s);
   endfunction

   initial begin
      repeat (20000) @(posedge clk_sys);
      num_errors++;
      $display("mismatch at %0t: watchdog expired", $time);
      end_of_test;
   end

   initial begin
      sys_rst <= 1'b1;
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} <= '0;
      {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} <= '0;
      {conv_done, conv_slot, conversion_result} <= '0;
      s_axi_wstrb <= 4'hf;
      num_errors = 0;
      comparisons = 0;
      repeat (20) @(posedge clk_sys);
      sys_rst <= 1'b0;
      @(negedge clk_sys);
      check_bit(irq, 1'b0);
      check_bit(low_limit_req, 1'b0);
      rd_chk(at(OFF_LOW_BASE, 3), 32'h0000_0000, 32'hffff);
      rd_chk(at(OFF_HIGH_BASE, 3), 32'h0000_7ff8, 32'hffff);
      rd_chk(OFF_READY, 32'h0000_0000, 32'hffff);
      rd_chk(OFF_CONTROL, 32'h0000_0000, 32'h3);
      axi_read(8'h1c, data, resp);
      check_word({30'h0000_0000, resp}, {30'h0000_0000, RESP_SLVERR}, 32'h3);
      axi_write(8'h1c, 32'h0000_ffff, resp);
      check_word({30'h0000_0000, resp}, {30'h0000_0000, RESP_SLVERR}, 32'h3);
      $display("test reset done");

      foreach (rows[i]) begin
         wr(at(OFF_LOW_BASE, rows[i].slot), {16'h0000, rows[i].lo});
         wr(at(OFF_HIGH_BASE, rows[i].slot), {16'h0000, rows[i].hi});
         conv(rows[i].slot, rows[i].raw);
         rd_chk(OFF_READY, 32'h1 << rows[i].slot, 32'hffff);
         rd_chk(OFF_LOW_STAT, 32'(rows[i].exp_lo) << rows[i].slot,
                32'hffff);
         rd_chk(OFF_HIGH_STAT, 32'(rows[i].exp_hi) << rows[i].slot,
                32'hffff);
         rd_chk(OFF_SUMMARY, {22'h0, rows[i].exp_lo, rows[i].exp_hi, 8'h0},
                32'h300);
         rd_chk(OFF_IRQ_STAT, {29'h0, rows[i].exp_hi, rows[i].exp_lo, 1'b1},
                32'h7);
         rd_chk(at(OFF_RESULT_BASE, rows[i].slot), {16'h0, rows[i].raw},
                32'h7ff8);
         rd_chk(OFF_READY, 32'h0000_0000, 32'hffff);
         wr(OFF_LOW_STAT, 32'h0000_ffff);
         wr(OFF_HIGH_STAT, 32'h0000_ffff);
         wr(OFF_IRQ_STAT, 32'h0000_0007);
         wr(at(OFF_LOW_BASE, rows[i].slot), 32'h0000_0000);
         wr(at(OFF_HIGH_BASE, rows[i].slot), 32'h0000_7ff8);
      end
      $display("test table done");

      wr(at(OFF_LOW_BASE, 1), 32'h0000_0100);
      wr(at(OFF_LOW_BASE, 4), 32'h0000_0100);
      wr(at(OFF_HIGH_BASE, 6), 32'h0000_0100);
      @(posedge clk_sys);
      conv_done         <= 1'b1;
      conv_slot         <= 4'd1;
      conversion_result <= 16'h0010;
      @(posedge clk_sys);
      conv_slot         <= 4'd4;
      @(posedge clk_sys);
      conv_done         <= 1'b0;
      conv(6, 16'h0200);
      @(negedge clk_sys);
      check_bit(low_limit_req, 1'b0);
      check_bit(high_limit_req, 1'b0);
      wr(OFF_CONTROL, 32'h0000_0003);
      @(negedge clk_sys);
      check_bit(low_limit_req, 1'b1);
      check_bit(high_limit_req, 1'b1);
      conv(1, 16'h0200);
      conv(4, 16'h0008);
      rd_chk(OFF_LOW_STAT, 32'h0000_0012, 32'hffff);
      wr(OFF_LOW_STAT, 32'h0000_0000);
      rd_chk(OFF_LOW_STAT, 32'h0000_0012, 32'hffff);
      wr(OFF_LOW_STAT, 32'h0000_0002);
      rd_chk(OFF_SUMMARY, 32'h0000_0300, 32'h300);
      wr(OFF_LOW_STAT, 32'h0000_0010);
      rd_chk(OFF_SUMMARY, 32'h0000_0100, 32'h300);
      check_bit(low_limit_req, 1'b0);
      wr(OFF_HIGH_STAT, 32'h0000_0040);
      rd_chk(OFF_SUMMARY, 32'h0000_0000, 32'h300);
      check_bit(high_limit_req, 1'b0);
      $display("test sticky and enables done");

      @(negedge clk_sys);
      check_bit(irq, 1'b0);
      wr(OFF_IRQ_MASK, 32'h0000_0002);
      @(negedge clk_sys);
      check_bit(irq, 1'b1);
      wr(OFF_IRQ_STAT, 32'h0000_0002);
      @(negedge clk_sys);
      check_bit(irq, 1'b0);
      wr(OFF_IRQ_MASK, 32'h0000_0007);
      @(negedge clk_sys);
      check_bit(irq, 1'b1);
      wr(OFF_IRQ_STAT, 32'h0000_0007);
      @(negedge clk_sys);
      check_bit(irq, 1'b0);
      @(posedge clk_sys);
      s_axi_wstrb <= 4'he;
      wr(OFF_CONTROL, 32'h0000_0000);
      rd_chk(OFF_CONTROL, 32'h0000_0003, 32'h3);
      @(posedge clk_sys);
      s_axi_wstrb <= 4'hf;
      $display("test interrupt done");
      end_of_test;
   end
endmodule
